// ==== qdi_slave.sv ====
// two-wire slave front end of a quad 12-bit converter: address, ack, frames, readback
// assumes scl/sda and the address strap arrive asynchronously; core values are mclk-synchronous
`timescale 1ns/10ps
module qdi_slave
	import qdi_pkg::*;
#(
	parameter logic [7:0] ID_HI  = 8'h5A,  // identity byte, value arbitrary
	parameter logic [2:0] ID_MID = 3'h0,   // identity bits, value arbitrary
	parameter logic [2:0] REV_ID = 3'h1    // revision, value arbitrary
)(
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	input  wire logic              ce,
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe,
	input  wire logic              addr_pu_in,
	input  wire logic              addr_pd_in,
	input  wire logic [3:0][11:0]  code_rb,
	input  wire logic [3:0][11:0]  dac_rb,
	input  wire logic [3:0]        pwr_down,
	input  wire logic [1:0]        ref_mode,
	output logic                   cmd_valid,
	input  wire logic              cmd_ready,
	output logic [23:0]            cmd_data,
	output logic                   busy
);

	// ****************************************
	// state record
	// ****************************************
	typedef struct packed {
		logic [2:0]      s_scl;     // [0] first flop, [2] third
		logic [2:0]      s_sda;
		logic [2:0][1:0] s_adr;
		logic            scl_f;
		logic            sda_f;
		qdi_state_t      st;
		logic [3:0]      bit_cnt;
		logic [7:0]      sh;
		logic [1:0]      phase;     // 0 addr, 1 cmd, 2 data hi, 3 data lo
		logic            rd;
		logic            ack;
		logic            mack;
		logic            start_hi;
		logic [7:0]      cmd;
		logic [7:0]      hi;
		logic            wr_xfer;
		logic            exec_any;
		logic            cmd_got;
		logic [7:0]      sel;
		logic            verify;
		logic [23:0]     last;
		logic [23:0]     rbuf;
		logic [1:0]      rd_idx;
		logic [1:0]      rd_len;
		logic [7:0]      tx;
		logic            oe;
		logic [1:0]      a_lo;
		logic [1:0]      strap_cnt;
		logic            strap_done;
	} qdi_slave_st_t;

	qdi_slave_st_t q;
	qdi_slave_st_t n;
	logic          scl_rise;
	logic          scl_fall;
	logic          start_ev;
	logic          stop_ev;
	logic          dec;
	logic          ack_go;
	logic          push;
	logic          tx_load;
	logic [15:0]   std_word;

	qdi_stream_if #(.W(FIFO_W)) f_if ();

	// ****************************************
	// readback word for the selected register
	// ****************************************
	function automatic logic [15:0] rb_word(
		input logic [7:0]       s,
		input logic [3:0][11:0] code_v,
		input logic [3:0][11:0] dac_v,
		input logic [3:0]       pd,
		input logic [1:0]       rm
	);
		logic [2:0]  grp;
		logic [1:0]  ch;
		logic [15:0] w;
		grp = s[GRP_LSB +: 3];
		// all-channel select (4..7) falls back to channel A
		ch  = s[CH_LSB + 2] ? 2'h0 : s[CH_LSB +: 2];
		w   = {ID_HI, ID_MID, REV_ID, rm};
		if (!s[7]) begin
			unique case (grp)
				GRP_CODE:                     w = {code_v[ch], 4'h0};
				GRP_LOAD, GRP_CLD_ALL, GRP_CLD: w = {dac_v[ch], 4'h0};
				GRP_POWER:                    w = {12'h000, pd};
				default:                      w = {ID_HI, ID_MID, REV_ID, rm};
			endcase
		end
		return w;
	endfunction

	assign std_word  = rb_word(q.sel, code_rb, dac_rb, pwr_down, ref_mode);
	assign f_if.data = {q.cmd, q.hi, q.sh};
	assign f_if.valid = push;
	assign sda_out   = 1'b0;   // open drain: only ever pulls low
	assign sda_oe    = q.oe;
	assign busy      = (q.st != QDI_IDLE);

	// ****************************************
	// next-state logic
	// ****************************************
	always_comb begin
		n       = q;
		ack_go  = 1'b0;
		push    = 1'b0;
		tx_load = 1'b0;
		// three-flop synchronisers; a level moves only when flops 2 and 3 agree
		n.s_scl = {q.s_scl[1:0], scl_in};
		n.s_sda = {q.s_sda[1:0], sda_in};
		n.s_adr = {q.s_adr[1:0], {addr_pu_in, addr_pd_in}};
		if (q.s_scl[1] == q.s_scl[2]) begin
			n.scl_f = q.s_scl[2];
		end
		if (q.s_sda[1] == q.s_sda[2]) begin
			n.sda_f = q.s_sda[2];
		end
		scl_rise = ce && n.scl_f && !q.scl_f;
		scl_fall = ce && !n.scl_f && q.scl_f;
		// sda edges only count while scl stays high across the cycle
		start_ev = ce && q.scl_f && n.scl_f && q.sda_f && !n.sda_f;
		stop_ev  = ce && q.scl_f && n.scl_f && !q.sda_f && n.sda_f;
		dec      = scl_fall && (q.st == QDI_RX) && (q.bit_cnt == BITS_BYTE);

		// strap captured once after release, the pad having settled
		if (!q.strap_done) begin
			if (q.strap_cnt == STRAP_WAIT && q.s_adr[1] == q.s_adr[2]) begin  // settled pad only
				n.a_lo       = {~(q.s_adr[2][1] & q.s_adr[2][0]), ~q.s_adr[2][1]};
				n.strap_done = 1'b1;
			end else begin
				n.strap_cnt = q.strap_cnt + 2'h1;
			end
		end

		if (start_ev || (stop_ev && !q.start_hi)) begin
			// end of a write transfer decides how the next read behaves
			if (q.wr_xfer) begin
				if (q.exec_any) begin
					n.verify = 1'b1;
				end else if (q.cmd_got) begin
					n.verify = 1'b0;
					n.sel    = q.cmd;
				end
			end
			// partial groups are simply dropped: nothing was pushed
			n.wr_xfer  = 1'b0;
			n.exec_any = 1'b0;
			n.cmd_got  = 1'b0;
			n.ack      = 1'b0;
			n.mack     = 1'b0;
			n.rd       = 1'b0;
			n.bit_cnt  = 4'h0;
			n.phase    = 2'h0;
			n.start_hi = start_ev;
			n.st       = start_ev ? QDI_RX : QDI_IDLE;
		end else begin
			if (scl_fall) begin
				n.start_hi = 1'b0;
			end
			unique case (q.st)
				QDI_IDLE, QDI_IGN: begin
				end
				QDI_RX: begin
					if (scl_rise) begin
						n.sh      = {q.sh[6:0], q.sda_f};
						n.bit_cnt = q.bit_cnt + 4'h1;
					end
					if (dec) begin
						unique case (q.phase)
							2'h0: begin
								if ((q.strap_done && q.sh[7:1] == {ADDR_HI5, q.a_lo}) ||
								    (q.sh == BCAST_BYTE)) begin
									ack_go    = 1'b1;
									n.rd      = q.sh[0];
									n.wr_xfer = !q.sh[0];
									n.phase   = 2'h1;
									if (q.sh[0]) begin
										// each read reloads from the first byte
										n.rd_idx = 2'h0;
										n.rbuf   = q.verify ? q.last : {std_word, ONES};
										n.rd_len = q.verify ? RB_LEN_VER : RB_LEN_STD;
										n.verify = 1'b0;  // one verification read per executing write transfer
									end
								end
							end
							2'h1: begin
								ack_go    = 1'b1;
								n.cmd     = q.sh;
								n.cmd_got = 1'b1;
								n.phase   = 2'h2;
							end
							2'h2: begin
								ack_go  = 1'b1;
								n.hi    = q.sh;
								n.phase = 2'h3;
							end
							2'h3: begin
								// full buffer refuses the group by withholding ack
								if (f_if.ready) begin
									ack_go     = 1'b1;
									push       = 1'b1;
									n.last     = {q.cmd, q.hi, q.sh};
									n.exec_any = 1'b1;
									n.phase    = q.cmd[MB_BIT] ? 2'h2 : 2'h1;
								end
							end
						endcase
						n.st = ack_go ? QDI_ACK : QDI_IGN;
						n.ack = ack_go;
						n.bit_cnt = 4'h0;
					end
				end
				QDI_ACK: begin
					// pull-down held until the ninth pulse has fallen
					if (scl_fall) begin
						n.ack = 1'b0;
						if (q.rd) begin
							tx_load  = 1'b1;
							n.st     = QDI_TX;
							n.tx     = q.rbuf[23:16];
							n.rd_idx = 2'h1;
						end else begin
							n.st = QDI_RX;
						end
					end
				end
				QDI_TX: begin
					if (scl_fall) begin
						if (q.bit_cnt == 4'h7) begin
							n.st      = QDI_TXACK;
							n.mack    = 1'b0;
							n.bit_cnt = 4'h0;
						end else begin
							n.tx      = {q.tx[6:0], 1'b1};
							n.bit_cnt = q.bit_cnt + 4'h1;
						end
					end
				end
				QDI_TXACK: begin
					if (scl_rise) begin
						// a not-acknowledge ends our part until the next start or stop
						n.mack = !q.sda_f;
						if (q.sda_f) begin
							n.st = QDI_IGN;
						end
					end
					if (scl_fall && q.mack) begin
						tx_load = 1'b1;
						n.st    = QDI_TX;
						if (q.rd_idx >= q.rd_len) begin
							n.tx = ONES;
						end else begin
							n.tx = q.rbuf[8'(23 - 8 * int'(q.rd_idx)) -: 8];
						end
						if (q.rd_idx != 2'h3) begin
							n.rd_idx = q.rd_idx + 2'h1;
						end
					end
				end
				default: begin
					n.st = QDI_IDLE;
				end
			endcase
		end
		n.oe = (n.st == QDI_ACK && n.ack) || (n.st == QDI_TX && !n.tx[7]);
		if (!ce) begin
			n = q;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			q        <= '0;
			q.s_scl  <= 3'h7;
			q.s_sda  <= 3'h7;
			q.scl_f  <= 1'b1;
			q.sda_f  <= 1'b1;
			q.st     <= QDI_IDLE;
		end else begin
			q <= n;
		end
	end

	// ****************************************
	// command buffer toward the converter core
	// ****************************************
	qdi_fifo #(
		.W (FIFO_W),
		.D (FIFO_D)
	) u_fifo (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.ce       (ce),
		.wr       (f_if.snk),
		.rd_valid (cmd_valid),
		.rd_ready (cmd_ready),
		.rd_data  (cmd_data)
	);

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	AST_STOP_ENDS: assert property (stop_ev && !q.start_hi && !start_ev |=> q.st == QDI_IDLE)
		else $error("stop did not end the transfer");
	AST_STOP_IN_START: assert property (stop_ev && q.start_hi |=> q.st == $past(q.st))
		else $error("stop in start high phase was acted on");
	AST_NO_PARTIAL: assert property ((stop_ev || start_ev) |-> !push ##1 !q.exec_any)
		else $error("frame executed across a stop or start");
	AST_READ_RESTART: assert property (dec && q.phase == 2'h0 && ack_go && q.sh[0] && !q.verify
		|=> q.rd_idx == 2'h0 && q.rbuf[23:8] == $past(std_word))
		else $error("combined read did not restart");
	AST_OWN_ADDR: assert property (dec && q.phase == 2'h0 && q.strap_done && q.sh[7:1] == {ADDR_HI5, q.a_lo}
		|=> q.st == QDI_ACK && sda_oe)
		else $error("own address not acknowledged");
	AST_STRAP: assert property ($rose(q.strap_done)
		|-> q.a_lo == {~&$past(q.s_adr[2]), ~$past(q.s_adr[2][1])})
		else $error("strap decoded wrongly");
	AST_RW_MODE: assert property (dec && q.phase == 2'h0 && ack_go |=> q.rd == $past(q.sh[0]))
		else $error("read/write mode not taken from address");
	AST_BCAST: assert property (dec && q.phase == 2'h0 && q.sh == BCAST_BYTE |-> ack_go)
		else $error("broadcast byte not acknowledged");
	AST_ACK_HOLD: assert property (q.st == QDI_ACK && q.ack && !scl_fall && !start_ev && !stop_ev
		|=> sda_oe throughout (q.st == QDI_ACK)[*1])
		else $error("acknowledge released early");
	AST_PUSH_FRAME: assert property (push |-> f_if.ready && q.phase == 2'h3
		##1 cmd_valid && q.last == $past(f_if.data))
		else $error("executed frame differs from staged bytes");
	AST_GROUP_NEXT: assert property (push && !q.cmd[MB_BIT] |=> q.phase == 2'h1)
		else $error("next group does not expect a command");
	AST_MULTIBYTE: assert property (push && q.cmd[MB_BIT] |=> q.phase == 2'h2)
		else $error("multibyte did not reuse the command");
	AST_ONES: assert property (tx_load && q.st == QDI_TXACK && q.rd_idx >= q.rd_len |=> q.tx == ONES)
		else $error("overrun byte not all ones");
	AST_VERIFY: assert property ((start_ev || stop_ev && !q.start_hi) && q.wr_xfer && q.exec_any
		|=> q.verify)
		else $error("verification mode not armed after write");
	AST_FILTER: assert property (q.scl_f != $past(q.scl_f) |-> $past(q.s_scl[1]) == $past(q.s_scl[2]))
		else $error("scl level moved without agreement");

endmodule

// ==== qdi_pkg.sv ====
// shared constants and types for the quad converter two-wire slave front end
// assumes a single 125 MHz system clock; no bus, every control bit is a port
package qdi_pkg;

	// ****************************************
	// address and command layout
	// ****************************************
	localparam logic [4:0] ADDR_HI5    = 5'h03;  // fixed upper address bits
	localparam logic [7:0] BCAST_BYTE  = 8'h10;  // broadcast address, write only
	localparam int         MB_BIT      = 6;      // multibyte flag in command byte
	localparam int         GRP_LSB     = 3;      // command group field
	localparam int         CH_LSB      = 0;      // channel select field
	localparam logic [2:0] GRP_CODE    = 3'h0;
	localparam logic [2:0] GRP_LOAD    = 3'h1;
	localparam logic [2:0] GRP_CLD_ALL = 3'h2;
	localparam logic [2:0] GRP_CLD     = 3'h3;
	localparam logic [2:0] GRP_POWER   = 3'h4;
	localparam logic [7:0] ONES        = 8'hFF;  // overrun readback filler

	// ****************************************
	// readback, strap and buffer sizing
	// ****************************************
	localparam logic [1:0] RB_LEN_STD  = 2'h2;   // combined read: two bytes
	localparam logic [1:0] RB_LEN_VER  = 2'h3;   // verification read: three bytes
	localparam logic [1:0] STRAP_WAIT  = 2'h3;   // cycles before strap capture
	localparam logic [3:0] BITS_BYTE   = 4'h8;
	localparam int         FIFO_W      = 24;
	localparam int         FIFO_D      = 8;

	// ****************************************
	// bus engine states, gray along idle-rx-ack-tx-txack
	// ****************************************
	typedef enum logic [2:0] {
		QDI_IDLE  = 3'h0,
		QDI_RX    = 3'h1,
		QDI_ACK   = 3'h3,
		QDI_TX    = 3'h7,
		QDI_TXACK = 3'h6,
		QDI_IGN   = 3'h4
	} qdi_state_t;

endpackage

// ==== qdi_stream_if.sv ====
// valid/ready carrier between the bus engine and its command buffer
// assumes both ends run on mclk
`timescale 1ns/10ps
interface qdi_stream_if #(parameter int W = 24);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ==== qdi_fifo.sv ====
// command buffer between the serial engine and the converter core
// assumes mclk domain on both sides; depth a power of two
`timescale 1ns/10ps
module qdi_fifo
	import qdi_pkg::*;
#(
	parameter int W = FIFO_W,
	parameter int D = FIFO_D
)(
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	input  wire logic         ce,
	qdi_stream_if.snk         wr,
	output logic              rd_valid,
	input  wire logic         rd_ready,
	output logic [W-1:0]      rd_data
);
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
	} qdi_fifo_st_t;

	qdi_fifo_st_t q_reg;
	qdi_fifo_st_t q_next;
	logic         push;
	logic         pop;

	// ****************************************
	// handshakes, frozen while ce is low
	// ****************************************
	assign wr.ready = ce && (q_reg.cnt != (AW+1)'(D));
	assign rd_valid = ce && (q_reg.cnt != '0);
	assign rd_data  = q_reg.mem[q_reg.rp];
	assign push     = wr.valid && wr.ready;
	assign pop      = rd_valid && rd_ready;

	// next state: write slot, advance pointers, track fill
	always_comb begin
		q_next = q_reg;
		if (push) begin
			q_next.mem[q_reg.wp] = wr.data;
			q_next.wp            = q_reg.wp + AW'(1);
		end
		if (pop) begin
			q_next.rp = q_reg.rp + AW'(1);
		end
		if (push && !pop) begin
			q_next.cnt = q_reg.cnt + (AW+1)'(1);
		end else if (pop && !push) begin
			q_next.cnt = q_reg.cnt - (AW+1)'(1);
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end
endmodule

// ==== qdi_master_model.sv ====
// two-wire bus master model: drives scl, pulls sda low, reads the resolved line
// assumes the bench resolves sda with a pull-up; half a bit lasts 8 mclk
`timescale 1ns/10ps
module qdi_master_model (
	input  wire logic mclk,
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda_line
);
	// bus idle at time zero
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// ****************************************
	// bit level helpers
	// ****************************************
	// each scl phase stays far above the 4 mclk minimum
	task automatic half();
		repeat (8) @(posedge mclk);
	endtask

	// gap after scl falls so sda never moves in the same filtered cycle
	task automatic gap();
		repeat (2) @(posedge mclk);
	endtask

	// start or repeated start: sda falls while scl high
	task automatic start();
		gap();
		sda_low <= 1'b0;
		half();
		scl <= 1'b1;
		half();
		sda_low <= 1'b1;
		half();
		scl <= 1'b0;
	endtask

	// stop: sda rises while scl high
	task automatic stop();
		gap();
		sda_low <= 1'b1;
		half();
		scl <= 1'b1;
		half();
		sda_low <= 1'b0;
		half();
	endtask

	// start then stop inside one scl high phase; the slave must ignore the stop
	task automatic start_stop();
		gap();
		sda_low <= 1'b0;
		half();
		scl <= 1'b1;
		half();
		sda_low <= 1'b1;
		half();
		sda_low <= 1'b0;
		half();
		scl <= 1'b0;
	endtask

	// one clock pulse; s is the line at the end of the high phase
	task automatic xbit(input logic b, output logic s);
		gap();
		sda_low <= ~b;
		half();
		scl <= 1'b1;
		half();
		s = sda_line;
		scl <= 1'b0;
	endtask

	// eight bits msb first, then a released ninth clock for the ack
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			xbit(b[i], s);
		end
		xbit(1'b1, s);
		ack = ~s;
	endtask

	// read a byte, then ack to continue or leave sda high on the last
	task automatic rbyte(input logic mack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			xbit(1'b1, s);
			b[i] = s;
		end
		xbit(~mack, s);
	endtask
endmodule

// ==== tb_quad_dac_i2c_slave_interface.sv ====
// self-checking bench for the two-wire slave front end
// assumes qdi_pkg, the stream interface, fifo and slave compiled before it
`timescale 1ns/10ps
module tb_quad_dac_i2c_slave_interface;
	import qdi_pkg::*;
	localparam logic [7:0]       T_ID  = 8'hA5;   // arbitrary identity byte
	localparam logic [2:0]       T_MID = 3'h2;    // arbitrary identity bits
	localparam logic [2:0]       T_REV = 3'h5;    // arbitrary revision
	localparam logic [3:0][11:0] CV    = {12'h4C4, 12'h3B3, 12'h2A2, 12'h191};
	localparam logic [3:0][11:0] DV    = {12'hE1E, 12'hD2D, 12'hC3C, 12'hB4B};
	localparam logic [15:0]      IDW   = {T_ID, T_MID, T_REV, 2'h2};
	// readback rows: select byte beside the two bytes it should return
	localparam logic [23:0]      ROWS [10] = '{
		{8'h01, CV[1], 4'h0}, {8'h07, CV[0], 4'h0}, {8'h41, CV[1], 4'h0},
		{8'h0A, DV[2], 4'h0}, {8'h13, DV[3], 4'h0}, {8'h1D, DV[0], 4'h0},
		{8'h20, 12'h000, 4'hA},
		{8'h28, IDW}, {8'h38, IDW}, {8'h80, IDW}};
	logic        mclk, sys_rst, ce, scl, sda_low, sda_in, sda_oe, sda_out, pu, pd;
	logic        cmd_valid, cmd_ready, busy, a;
	logic [23:0] cmd_data;
	logic [7:0]  rd;
	int          n_mismatch, checked;

	// open-drain data line with pull-up; the pad shows sda_out while enabled
	assign sda_in = ~sda_low & (sda_oe ? sda_out : 1'b1);

	qdi_master_model m (.mclk(mclk), .scl(scl), .sda_low(sda_low), .sda_line(sda_in));

	qdi_slave #(.ID_HI(T_ID), .ID_MID(T_MID), .REV_ID(T_REV)) uut (
		.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .scl_in(scl), .sda_in(sda_in),
		.sda_out(sda_out), .sda_oe(sda_oe), .addr_pu_in(pu), .addr_pd_in(pd),
		.code_rb(CV), .dac_rb(DV), .pwr_down(4'hA), .ref_mode(2'h2),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data), .busy(busy));

	// 125 MHz clock
	always #4 mclk = ~mclk;

	// ****************************************
	// compare and report
	// ****************************************
	task automatic chk1(input string nm, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk24(input string nm, input logic [23:0] e, input logic [23:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// transfer helpers
	// ****************************************
	// reset with a strap state; flags must sit at rest while held
	task automatic do_reset(input logic p_u, input logic p_d);
		@(posedge mclk);
		sys_rst <= 1'b1;
		pu <= p_u;
		pd <= p_d;
		repeat (20) @(posedge mclk);
		@(negedge mclk);
		chk1("rst sda_oe", 1'b0, sda_oe);
		chk1("rst valid", 1'b0, cmd_valid);
		chk1("rst busy", 1'b0, busy);
		@(posedge mclk);
		sys_rst <= 1'b0;
		repeat (10) @(posedge mclk);
	endtask

	// own address with the vdd strap
	function automatic logic [7:0] ad(input logic rw);
		return {ADDR_HI5, 2'h0, rw};
	endfunction

	task automatic wr(input logic [7:0] q[$]);
		m.start();
		foreach (q[i]) begin
			m.wbyte(q[i], a);
			chk1("ack", 1'b1, a);
		end
		m.stop();
	endtask

	// bounded wait for a buffered frame, compare, then take it
	task automatic pop(input logic [23:0] e);
		int i;
		@(negedge mclk);
		for (i = 0; i < 300 && cmd_valid !== 1'b1; i++) begin
			@(negedge mclk);
		end
		if (cmd_valid !== 1'b1) begin
			n_mismatch++;
			$display("ERROR cmd_valid expected 1 seen timeout");
			end_sim();
		end else begin
			chk24("cmd_data", e, cmd_data);
			@(posedge mclk);
			cmd_ready <= 1'b1;
			@(posedge mclk);
			cmd_ready <= 1'b0;
		end
	endtask

	// select, repeated start, read two bytes and one overrun byte
	task automatic rb(input logic [7:0] sel, input logic [15:0] e);
		m.start();
		m.wbyte(ad(1'b0), a);
		m.wbyte(sel, a);
		m.start();
		m.wbyte(ad(1'b1), a);
		chk1("rd ack", 1'b1, a);
		m.rbyte(1'b1, rd);
		chk8("rb hi", e[15:8], rd);
		m.rbyte(1'b1, rd);
		chk8("rb lo", e[7:0], rd);
		m.rbyte(1'b0, rd);
		chk8("rb pad", ONES, rd);
		m.stop();
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		logic [1:0] lo;
		mclk = 1'b0;
		sys_rst = 1'b1;
		ce = 1'b1;
		pu = 1'b1;
		pd = 1'b1;
		cmd_ready = 1'b0;
		n_mismatch = 0;
		checked = 0;
		// strap states ground, open, vdd; the inverted pair must be refused
		for (int i = 0; i < 3; i++) begin
			do_reset(i > 0, i > 1);
			lo = (i == 0) ? 2'h3 : (i == 1) ? 2'h2 : 2'h0;
			wr('{{ADDR_HI5, lo, 1'b0}});
			m.start();
			m.wbyte({ADDR_HI5, ~lo, 1'b0}, a);
			m.stop();
			chk1("foreign addr", 1'b0, a);
		end
		for (int i = 0; i < 10; i++) begin
			rb(ROWS[i][23:16], ROWS[i][15:0]);
		end
		// plain group, then a multibyte command repeated twice
		wr('{ad(1'b0), 8'h01, 8'h11, 8'h22, 8'h42, 8'h33, 8'h44, 8'h55, 8'h66});
		pop(24'h011122);
		pop(24'h423344);
		pop(24'h425566);
		// read after a full write returns the last executed frame
		m.start();
		m.wbyte(ad(1'b1), a);
		for (int i = 0; i < 4; i++) begin
			m.rbyte(i < 3, rd);
			chk8("verify", (i == 0) ? 8'h42 : (i == 1) ? 8'h55 : (i == 2) ? 8'h66 : ONES, rd);
		end
		m.stop();
		// incomplete group, cut by a stop in mid-byte
		m.start();
		m.wbyte(ad(1'b0), a);
		m.wbyte(8'h05, a);
		m.wbyte(8'h77, a);
		repeat (3) m.xbit(1'b1, a);
		m.stop();
		repeat (40) @(posedge mclk);
		@(negedge mclk);
		chk1("no frame", 1'b0, cmd_valid);
		wr('{ad(1'b0), 8'h02, 8'h12, 8'h34});
		pop(24'h021234);
		// start and stop in one scl high: the stop is ignored, a later one counts
		m.start_stop();
		@(negedge mclk);
		chk1("stop in start", 1'b1, busy);
		m.stop();
		@(negedge mclk);
		chk1("stop ends", 1'b0, busy);
		// stop inside a readback byte, later read starts over
		m.start();
		m.wbyte(ad(1'b0), a);
		m.wbyte(8'h01, a);
		m.start();
		m.wbyte(ad(1'b1), a);
		repeat (4) m.xbit(1'b1, a);
		m.stop();
		m.start();
		m.wbyte(ad(1'b1), a);
		m.rbyte(1'b0, rd);
		m.stop();
		chk8("restart hi", CV[1][11:4], rd);
		// broadcast write, used for writes only
		wr('{BCAST_BYTE, 8'h03, 8'hAB, 8'hCD});
		pop(24'h03ABCD);
		// fill the buffer, then the last data byte must be refused
		for (int k = 0; k < 8; k++) begin
			wr('{ad(1'b0), 8'(k), 8'h5A, 8'(k + 16)});
		end
		m.start();
		m.wbyte(ad(1'b0), a);
		m.wbyte(8'h09, a);
		m.wbyte(8'h99, a);
		m.wbyte(8'h88, a);
		m.stop();
		chk1("full nack", 1'b0, a);
		// clock enable low freezes the buffer and gates its valid
		@(posedge mclk);
		ce <= 1'b0;
		repeat (4) @(posedge mclk);
		@(negedge mclk);
		chk1("ce frozen", 1'b0, cmd_valid);
		@(posedge mclk);
		ce <= 1'b1;
		@(negedge mclk);
		chk1("ce resumed", 1'b1, cmd_valid);
		for (int k = 0; k < 8; k++) begin
			pop({8'(k), 8'h5A, 8'(k + 16)});
		end
		// the refused group is retried once room is back
		wr('{ad(1'b0), 8'h09, 8'h99, 8'h88});
		pop(24'h099988);
		repeat (4) @(posedge mclk);
		@(negedge mclk);
		chk1("drained", 1'b0, cmd_valid);
		end_sim();
	end

	// watchdog against a hung transfer
	initial begin
		repeat (100000) @(posedge mclk);
		n_mismatch++;
		$display("ERROR run expected done seen timeout");
		end_sim();
	end
endmodule
